// ==== hdl/rwt_cfg_if.sv ====
`default_nettype none

module rwt_cfg_if
(
	input wire logic clk, // Core clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic wr_stb, // Configuration write strobe.
	input wire logic wr_mode, // Mode written with the strobe.
	input wire logic wr_enable, // Enable written with the strobe.
	input wire logic wr_comp_en, // Compensation enable written with the strobe.
	input wire logic [rwt_pkg::CNT_W-1:0] wr_value, // Duration or target time.
	input wire logic clr_stb, // Interrupt clear strobe.
	input wire logic rd_stb, // Counter read strobe.
	input wire logic [rwt_pkg::CNT_W-1:0] live_count, // Running counter value.
	output logic mode_ff, // Held mode.
	output logic enable_ff, // Held enable.
	output logic comp_en_ff, // Held compensation enable.
	output logic [rwt_pkg::CNT_W-1:0] value_ff, // Held duration or target.
	output logic arm_ff, // One-cycle pulse after each write.
	output logic clr_ff, // One-cycle pulse after each clear strobe.
	output logic [rwt_pkg::CNT_W-1:0] rd_value_ff, // Captured counter value.
	output logic rd_valid_ff // One-cycle pulse with a fresh capture.
);

	// Every write re-arms the timer, so the whole configuration is taken at once.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_ff <= rwt_pkg::MODE_COUNTDOWN;
			enable_ff <= 1'h0;
			comp_en_ff <= 1'h0;
			value_ff <= rwt_pkg::CNT_RST;
		end
		else if (wr_stb)
		begin
			mode_ff <= wr_mode;
			enable_ff <= wr_enable;
			comp_en_ff <= wr_comp_en;
			value_ff <= wr_value;
		end
	end

	// Strobes become pulses that line up with the held configuration.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			arm_ff <= 1'h0;
			clr_ff <= 1'h0;
		end
		else
		begin
			arm_ff <= wr_stb;
			clr_ff <= clr_stb;
		end
	end

	// A capture freezes all 64 bits in one edge, so software never sees a torn value.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_value_ff <= rwt_pkg::CNT_RST;
			rd_valid_ff <= 1'h0;
		end
		else
		begin
			rd_valid_ff <= rd_stb;
			if (rd_stb)
			begin
				rd_value_ff <= live_count;
			end
		end
	end

endmodule // rwt_cfg_if

`default_nettype wire

// ==== hdl/rwt_pkg.sv ====
`default_nettype none

package rwt_pkg;

	// Width of the wake-up counter and of every time value that meets it.
	localparam int CNT_W = 64;
	localparam logic [CNT_W-1:0] CNT_RST = 64'h0000_0000_0000_0000;

	// Clock rates.
	localparam longint SLOW_HZ = 64'h0000_0000_0000_8000; // 32.768 kHz slow clock.
	localparam longint REF_HZ = 64'h0000_0000_01e8_4800; // 32 MHz reference.
	localparam longint CORE_HZ = 64'h0000_0000_0262_5a00; // 40 MHz core clock.

	// The estimator window is 1024 slow ticks, so nominally exactly one million reference ticks fall inside.
	// One reference tick of error is then one ppm, which spares a divider.
	localparam longint EST_WIN_TICKS = 64'h0000_0000_0000_0400;
	localparam int EST_WIN_W = 10;
	localparam logic [EST_WIN_W-1:0] EST_WIN_LAST = EST_WIN_W'(EST_WIN_TICKS - 64'h1);
	localparam logic [EST_WIN_W-1:0] EST_WIN_RST = 10'h000;
	localparam int REF_CNT_W = 21;
	localparam logic [REF_CNT_W-1:0] EST_NOMINAL = REF_CNT_W'((EST_WIN_TICKS * REF_HZ) / SLOW_HZ);
	localparam logic [REF_CNT_W-1:0] REF_CNT_MAX = 21'h1f_ffff;
	localparam logic [REF_CNT_W-1:0] REF_CNT_RST = 21'h00_0000;

	// Offset in ppm and the compensation phase accumulator.
	localparam int PPM_W = 22;
	localparam logic [PPM_W-1:0] PPM_RST = 22'h00_0000;
	localparam int ACC_W = 24;
	localparam logic [ACC_W-1:0] ACC_RST = 24'h00_0000;
	localparam logic signed [ACC_W-1:0] ACC_UNITY = ACC_W'(EST_NOMINAL);

	// Counter step per slow tick after compensation.
	localparam logic [1:0] STEP_DROP = 2'h0;
	localparam logic [1:0] STEP_ONE = 2'h1;
	localparam logic [1:0] STEP_TWO = 2'h2;

	// Timer modes.
	localparam logic MODE_COUNTDOWN = 1'h0;
	localparam logic MODE_FREERUN = 1'h1;

	// Timer states, Gray coded along idle, armed, fired.
	typedef enum logic [1:0]
	{
		TMR_IDLE = 2'h0,
		TMR_ARMED = 2'h1,
		TMR_FIRED = 2'h3
	} rwt_tmr_type;

endpackage

`default_nettype wire

// ==== hdl/rwt_wakeup_timer.sv ====
`default_nettype none

module rwt_wakeup_timer
(
	input wire logic CORE_CLK, // Core clock, 40 MHz.
	input wire logic RSTN, // Asynchronous reset, active low.
	input wire logic SLOW_CLK, // 32.768 kHz slow clock pin, sampled.
	input wire logic REF_TICK, // One-cycle enable at the 32 MHz reference rate.
	input wire logic SLEEP_IN, // High while the system is in a sleep state.
	input wire logic CFG_WR_STB, // Write configuration and re-arm.
	input wire logic CFG_MODE, // 0 countdown, 1 free running.
	input wire logic CFG_ENABLE, // Timer enable.
	input wire logic CFG_COMP_EN, // Offset compensation enable.
	input wire logic [rwt_pkg::CNT_W-1:0] CFG_VALUE, // Duration or target time.
	input wire logic CFG_CLR_STB, // Clear the interrupt.
	input wire logic CFG_RD_STB, // Capture the counter.
	output logic [rwt_pkg::CNT_W-1:0] RD_VALUE, // Captured counter value.
	output logic RD_VALID, // Capture done pulse.
	output logic signed [rwt_pkg::PPM_W-1:0] OFFSET_PPM, // Slow clock offset in ppm.
	output logic OFFSET_VALID, // A full window has been measured.
	output logic TIMER_ARMED, // Timer is armed and waiting.
	output logic IRQ, // Timer interrupt, level.
	output logic WAKE_REQ // Wake request to power control.
);

	logic mode_ff;
	logic enable_ff;
	logic comp_en_ff;
	logic [rwt_pkg::CNT_W-1:0] value_ff;
	logic arm_ff;
	logic clr_ff;
	logic sl_meta_ff, sl_sync_ff, sl_prev_ff;
	logic slow_tick;
	logic [rwt_pkg::EST_WIN_W-1:0] win_cnt_ff;
	logic [rwt_pkg::REF_CNT_W-1:0] ref_cnt_ff;
	logic signed [rwt_pkg::PPM_W-1:0] ppm_ff;
	logic signed [rwt_pkg::PPM_W-1:0] nxt_ppm;
	logic est_valid_ff;
	logic signed [rwt_pkg::ACC_W-1:0] acc_ff;
	logic signed [rwt_pkg::ACC_W-1:0] nxt_acc;
	logic signed [rwt_pkg::ACC_W-1:0] acc_sum;
	logic [1:0] step;
	logic [rwt_pkg::CNT_W-1:0] cnt_ff;
	logic [rwt_pkg::CNT_W-1:0] step_w;
	logic [rwt_pkg::CNT_W-1:0] tgt_dist;
	logic hit_zero;
	logic hit_target;
	logic fire;
	rwt_pkg::rwt_tmr_type state_ff;
	rwt_pkg::rwt_tmr_type nxt_state;
	logic irq_ff;
	logic wake_ff;
	logic armed_ff;

	// Configuration and read-back live in their own sub-module.
	rwt_cfg_if u_cfg
	(
		.clk(CORE_CLK),
		.rst_n(RSTN),
		.wr_stb(CFG_WR_STB),
		.wr_mode(CFG_MODE),
		.wr_enable(CFG_ENABLE),
		.wr_comp_en(CFG_COMP_EN),
		.wr_value(CFG_VALUE),
		.clr_stb(CFG_CLR_STB),
		.rd_stb(CFG_RD_STB),
		.live_count(cnt_ff),
		.mode_ff(mode_ff),
		.enable_ff(enable_ff),
		.comp_en_ff(comp_en_ff),
		.value_ff(value_ff),
		.arm_ff(arm_ff),
		.clr_ff(clr_ff),
		.rd_value_ff(RD_VALUE),
		.rd_valid_ff(RD_VALID)
	);

	// The slow clock is foreign to the core clock, so it is synchronised before edge detection.
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			sl_meta_ff <= 1'h0;
			sl_sync_ff <= 1'h0;
			sl_prev_ff <= 1'h0;
		end
		else
		begin
			sl_meta_ff <= SLOW_CLK;
			sl_sync_ff <= sl_meta_ff;
			sl_prev_ff <= sl_sync_ff;
		end
	end

	// One enable pulse per rising slow edge drives everything that runs at the slow rate.
	assign slow_tick = sl_sync_ff & ~sl_prev_ff;

	// The offset is the nominal million minus what was counted; a fast slow clock gives a positive value.
	assign nxt_ppm = $signed({1'b0, rwt_pkg::EST_NOMINAL}) - $signed({1'b0, ref_cnt_ff});

	// Window counter over slow ticks.
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			win_cnt_ff <= rwt_pkg::EST_WIN_RST;
		end
		else if (slow_tick)
		begin
			win_cnt_ff <= (win_cnt_ff == rwt_pkg::EST_WIN_LAST) ? rwt_pkg::EST_WIN_RST : win_cnt_ff + 10'h001;
		end
	end

	// Reference ticks within the window; saturation keeps a dead slow clock from wrapping to a small error.
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			ref_cnt_ff <= rwt_pkg::REF_CNT_RST;
		end
		else if (slow_tick && (win_cnt_ff == rwt_pkg::EST_WIN_LAST))
		begin
			ref_cnt_ff <= REF_TICK ? 21'h00_0001 : rwt_pkg::REF_CNT_RST;
		end
		else if (REF_TICK && (ref_cnt_ff != rwt_pkg::REF_CNT_MAX))
		begin
			ref_cnt_ff <= ref_cnt_ff + 21'h00_0001;
		end
	end

	// The result is taken at each window end and held until the next one.
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			ppm_ff <= rwt_pkg::PPM_RST;
			est_valid_ff <= 1'h0;
		end
		else if (slow_tick && (win_cnt_ff == rwt_pkg::EST_WIN_LAST))
		begin
			ppm_ff <= nxt_ppm;
			est_valid_ff <= 1'h1;
		end
	end

	// Each tick adds the offset to a phase accumulator; a whole million means one tick to drop or add.
	// Only one correction is made per tick, which limits the usable range to well beyond any crystal.
	always_comb
	begin
		acc_sum = acc_ff;
		if (comp_en_ff && est_valid_ff)
		begin
			acc_sum = acc_ff + rwt_pkg::ACC_W'(ppm_ff);
		end
		nxt_acc = acc_sum;
		step = rwt_pkg::STEP_ONE;
		if (acc_sum >= rwt_pkg::ACC_UNITY)
		begin
			nxt_acc = acc_sum - rwt_pkg::ACC_UNITY;
			step = rwt_pkg::STEP_DROP;
		end
		else if (acc_sum <= -rwt_pkg::ACC_UNITY)
		begin
			nxt_acc = acc_sum + rwt_pkg::ACC_UNITY;
			step = rwt_pkg::STEP_TWO;
		end
	end

	// Accumulator advances only on slow ticks.
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			acc_ff <= rwt_pkg::ACC_RST;
		end
		else if (slow_tick)
		begin
			acc_ff <= nxt_acc;
		end
	end

	// A step of two may jump over the target, so the test is whether the target lies in the span stepped.
	assign step_w = rwt_pkg::CNT_W'(step);
	assign tgt_dist = value_ff - cnt_ff - 64'h0000_0000_0000_0001;
	assign hit_target = (mode_ff == rwt_pkg::MODE_FREERUN) && (tgt_dist < step_w);
	assign hit_zero = (mode_ff == rwt_pkg::MODE_COUNTDOWN) && (step != rwt_pkg::STEP_DROP) && (cnt_ff <= step_w);
	assign fire = slow_tick && (state_ff == rwt_pkg::TMR_ARMED) && !arm_ff && (hit_target || hit_zero);

	// The counter needs nothing but the core clock and the slow pin, so it keeps running in deep sleep.
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			cnt_ff <= rwt_pkg::CNT_RST;
		end
		else if (arm_ff && (mode_ff == rwt_pkg::MODE_COUNTDOWN))
		begin
			cnt_ff <= value_ff;
		end
		else if (slow_tick && (mode_ff == rwt_pkg::MODE_FREERUN))
		begin
			cnt_ff <= cnt_ff + step_w;
		end
		else if (slow_tick && (state_ff == rwt_pkg::TMR_ARMED))
		begin
			cnt_ff <= hit_zero ? rwt_pkg::CNT_RST : cnt_ff - step_w;
		end
	end

	// Timer state: a write arms or disarms, a hit moves to fired until the next write.
	always_comb
	begin
		unique case (state_ff)
			rwt_pkg::TMR_IDLE, rwt_pkg::TMR_FIRED:
			begin
				nxt_state = state_ff;
			end
			rwt_pkg::TMR_ARMED:
			begin
				nxt_state = fire ? rwt_pkg::TMR_FIRED : rwt_pkg::TMR_ARMED;
			end
			default:
			begin
				nxt_state = rwt_pkg::TMR_IDLE;
			end
		endcase
		if (arm_ff)
		begin
			nxt_state = enable_ff ? rwt_pkg::TMR_ARMED : rwt_pkg::TMR_IDLE;
		end
	end

	// State register, with the armed decode kept in its own flop so the pin has no decode glitches.
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			state_ff <= rwt_pkg::TMR_IDLE;
			armed_ff <= 1'h0;
		end
		else
		begin
			state_ff <= nxt_state;
			armed_ff <= (nxt_state == rwt_pkg::TMR_ARMED);
		end
	end

	// The interrupt is sticky; a new hit wins over a clear in the same cycle, and a re-arm blocks the hit and clears.
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			irq_ff <= 1'h0;
		end
		else if (fire)
		begin
			irq_ff <= 1'h1;
		end
		else if (clr_ff || arm_ff)
		begin
			irq_ff <= 1'h0;
		end
	end

	// A pending interrupt during sleep asks power control to wake the system.
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			wake_ff <= 1'h0;
		end
		else
		begin
			wake_ff <= irq_ff && SLEEP_IN;
		end
	end

	// Outputs straight from flip-flops.
	assign IRQ = irq_ff;
	assign WAKE_REQ = wake_ff;
	assign OFFSET_PPM = ppm_ff;
	assign OFFSET_VALID = est_valid_ff;
	assign TIMER_ARMED = armed_ff;

endmodule // rwt_wakeup_timer

`default_nettype wire

// ==== sim/rwt_wakeup_timer_assertions.sv ====
`default_nettype none

// Port checks; a write or clear strobe shows at the outputs two edges after it is taken, a read strobe one edge after.
module rwt_wakeup_timer_chk
(
	input wire logic CORE_CLK, // Clock.
	input wire logic RSTN, // Reset.
	input wire logic SLEEP_IN, // Asleep.
	input wire logic CFG_WR_STB, // Write.
	input wire logic CFG_ENABLE, // Enable.
	input wire logic CFG_CLR_STB, // Clear.
	input wire logic CFG_RD_STB, // Read.
	input wire logic [rwt_pkg::CNT_W-1:0] RD_VALUE, // Capture.
	input wire logic RD_VALID, // Pulse.
	input wire logic OFFSET_VALID, // Valid.
	input wire logic TIMER_ARMED, // Armed.
	input wire logic IRQ, // Interrupt.
	input wire logic WAKE_REQ // Wake.
);
	timeunit 1ns;
	timeprecision 1ps;

	// All checks use the core clock and rest in reset.
	default clocking @(posedge CORE_CLK);
	endclocking
	default disable iff (!RSTN);

	// Lone strobes, the arm and clear ones on an idle timer, so that no pending hit can win over them.
	sequence s_arm;
		CFG_WR_STB && CFG_ENABLE && !TIMER_ARMED ##1 !CFG_WR_STB && !TIMER_ARMED;
	endsequence
	sequence s_off;
		CFG_WR_STB && !CFG_ENABLE ##1 !CFG_WR_STB;
	endsequence
	sequence s_clr;
		CFG_CLR_STB && !CFG_WR_STB && !$past(CFG_WR_STB) && !TIMER_ARMED ##1 !CFG_WR_STB && !TIMER_ARMED;
	endsequence

	property p_arm;
		s_arm |=> TIMER_ARMED;
	endproperty
	a_arm: assert property (p_arm) else $error("no arm");
	property p_off;
		s_off |=> !TIMER_ARMED;
	endproperty
	a_off: assert property (p_off) else $error("no disarm");
	property p_clr;
		s_clr |=> !IRQ;
	endproperty
	a_clr: assert property (p_clr) else $error("no clear");
	property p_sticky;
		IRQ && !CFG_CLR_STB && !CFG_WR_STB && !$past(CFG_CLR_STB) && !$past(CFG_WR_STB) |=> IRQ;
	endproperty
	a_sticky: assert property (p_sticky) else $error("irq dropped");
	property p_fire;
		$rose(IRQ) |-> $past(TIMER_ARMED) && !TIMER_ARMED;
	endproperty
	a_fire: assert property (p_fire) else $error("bad fire");
	property p_wake;
		##1 WAKE_REQ == $past(IRQ && SLEEP_IN);
	endproperty
	a_wake: assert property (p_wake) else $error("bad wake");
	property p_rd;
		CFG_RD_STB |=> RD_VALID;
	endproperty
	a_rd: assert property (p_rd) else $error("no capture");
	property p_rd_hold;
		!RD_VALID |-> $stable(RD_VALUE);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("capture moved");
	property p_ofs;
		OFFSET_VALID |=> OFFSET_VALID;
	endproperty
	a_ofs: assert property (p_ofs) else $error("valid lost");
endmodule // rwt_wakeup_timer_chk

`default_nettype wire

// ==== sim/rwt_wakeup_timer_bench.sv ====
`default_nettype none

// Runs countdown, free-run, capture, estimator and compensation.
module rwt_wakeup_timer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic CORE_CLK = 1'h0;
	logic RSTN = 1'h0;
	logic SLOW_CLK = 1'h0;
	logic REF_TICK = 1'h1;
	logic SLEEP_IN = 1'h0;
	logic CFG_WR_STB = 1'h0;
	logic CFG_MODE = 1'h0;
	logic CFG_ENABLE = 1'h0;
	logic CFG_COMP_EN = 1'h0;
	logic [rwt_pkg::CNT_W-1:0] CFG_VALUE = 64'h0;
	logic CFG_CLR_STB = 1'h0;
	logic CFG_RD_STB = 1'h0;
	logic [rwt_pkg::CNT_W-1:0] RD_VALUE;
	logic signed [rwt_pkg::PPM_W-1:0] OFFSET_PPM;
	logic RD_VALID, OFFSET_VALID, TIMER_ARMED, IRQ, WAKE_REQ;
	logic [3:0] div_ff = 4'h0;
	logic [rwt_pkg::CNT_W-1:0] ca, cb;
	int error_cnt = 0;
	int checks_done = 0;
	int n;

	// Core clock, 25 ns period.
	initial forever #12.5 CORE_CLK = ~CORE_CLK;

	// Slow pin sped up to 20 core cycles a period so a 1024-tick window fits the run.
	always @(posedge CORE_CLK)
	begin
		div_ff <= (div_ff == 4'h9) ? 4'h0 : div_ff + 4'h1;
		if (div_ff == 4'h9)
			SLOW_CLK <= ~SLOW_CLK;
	end

	rwt_wakeup_timer u_rwt_wakeup_timer
	(
		.CORE_CLK(CORE_CLK), .RSTN(RSTN), .SLOW_CLK(SLOW_CLK), .REF_TICK(REF_TICK), .SLEEP_IN(SLEEP_IN),
		.CFG_WR_STB(CFG_WR_STB), .CFG_MODE(CFG_MODE), .CFG_ENABLE(CFG_ENABLE), .CFG_COMP_EN(CFG_COMP_EN),
		.CFG_VALUE(CFG_VALUE), .CFG_CLR_STB(CFG_CLR_STB), .CFG_RD_STB(CFG_RD_STB), .RD_VALUE(RD_VALUE),
		.RD_VALID(RD_VALID), .OFFSET_PPM(OFFSET_PPM), .OFFSET_VALID(OFFSET_VALID),
		.TIMER_ARMED(TIMER_ARMED), .IRQ(IRQ), .WAKE_REQ(WAKE_REQ)
	);

	// Comparison counting and reporting.
	function automatic bit ok(input bit c);
		checks_done++;
		return c;
	endfunction
	task automatic fail(input string m);
		error_cnt++;
		$display("[ERR] %0t %s", $time, m);
	endtask
	task automatic tk(input int k);
		repeat (k) @(posedge CORE_CLK);
		#1;
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Strobe tasks end at the edge that takes the strobe.
	task automatic wr(input logic md, input logic en, input logic cp, input logic [rwt_pkg::CNT_W-1:0] v);
		@(posedge CORE_CLK);
		CFG_WR_STB <= 1'h1;
		CFG_MODE <= md;
		CFG_ENABLE <= en;
		CFG_COMP_EN <= cp;
		CFG_VALUE <= v;
		@(posedge CORE_CLK);
		CFG_WR_STB <= 1'h0;
	endtask
	task automatic rd(output logic [rwt_pkg::CNT_W-1:0] v);
		@(posedge CORE_CLK);
		CFG_RD_STB <= 1'h1;
		@(posedge CORE_CLK);
		CFG_RD_STB <= 1'h0;
		#1;
		if (!ok(RD_VALID === 1'h1)) fail("no capture pulse");
		v = RD_VALUE;
	endtask
	task automatic wait_irq();
		n = 0;
		while (IRQ !== 1'h1 && n < 200)
		begin
			tk(1);
			n++;
		end
	endtask

	// Free count over exactly five ticks.
	task automatic t_read();
		wr(1'h1, 1'h0, 1'h0, 64'h0);
		rd(ca);
		tk(98);
		rd(cb);
		if (!ok(cb - ca === 64'h5)) fail("count rate");
	endtask

	// Countdown of three ticks while asleep, then hold and clear.
	task automatic t_countdown();
		@(posedge CORE_CLK);
		SLEEP_IN <= 1'h1;
		wr(1'h0, 1'h1, 1'h0, 64'h3);
		tk(1);
		if (!ok(TIMER_ARMED === 1'h1)) fail("not armed");
		wait_irq();
		if (!ok(n >= 40 && n <= 62 && TIMER_ARMED === 1'h0)) fail("countdown length");
		tk(1);
		if (!ok(WAKE_REQ === 1'h1)) fail("no wake");
		tk(60);
		if (!ok(IRQ === 1'h1)) fail("irq not held");
		@(posedge CORE_CLK);
		CFG_CLR_STB <= 1'h1;
		SLEEP_IN <= 1'h0;
		@(posedge CORE_CLK);
		CFG_CLR_STB <= 1'h0;
		tk(1);
		if (!ok(IRQ === 1'h0)) fail("irq not cleared");
	endtask

	// Target six ticks ahead of a fresh capture; re-arm must clear.
	task automatic t_free();
		rd(ca);
		wr(1'h1, 1'h1, 1'h0, ca + 64'h6);
		wait_irq();
		rd(cb);
		if (!ok(IRQ === 1'h1 && cb === ca + 64'h6)) fail("target miss");
		wr(1'h1, 1'h0, 1'h0, 64'h0);
		tk(1);
		if (!ok(IRQ === 1'h0 && TIMER_ARMED === 1'h0)) fail("re-arm");
	endtask

	// With a reference tick every cycle a window holds 20480 ticks.
	task automatic t_offset();
		n = 0;
		while (OFFSET_VALID !== 1'h1 && n < 30000)
		begin
			tk(1);
			n++;
		end
		tk(20500);
		if (!ok(OFFSET_VALID === 1'h1 && OFFSET_PPM === 22'h0e_f240)) fail("offset");
	endtask

	// A large positive offset must drop most steps over ten ticks.
	task automatic t_comp();
		wr(1'h1, 1'h0, 1'h1, 64'h0);
		rd(ca);
		tk(198);
		rd(cb);
		if (!ok(cb - ca < 64'h5)) fail("no compensation");
	endtask

	// Main sequence.
	initial
	begin
		repeat (20) @(posedge CORE_CLK);
		RSTN <= 1'h1;
		tk(1);
		if (!ok({IRQ, TIMER_ARMED, RD_VALID, OFFSET_VALID, WAKE_REQ} === 5'h00)) fail("reset state");
		t_read();
		t_countdown();
		t_free();
		t_offset();
		t_comp();
		print_verdict();
	end

	// The sequence needs about 41000 cycles.
	initial
	begin
		repeat (60000) @(posedge CORE_CLK);
		fail("watchdog");
		print_verdict();
	end
endmodule // rwt_wakeup_timer_bench

bind rwt_wakeup_timer rwt_wakeup_timer_chk u_rwt_wakeup_timer_chk
(
	.CORE_CLK(CORE_CLK), .RSTN(RSTN), .SLEEP_IN(SLEEP_IN), .CFG_WR_STB(CFG_WR_STB), .CFG_ENABLE(CFG_ENABLE),
	.CFG_CLR_STB(CFG_CLR_STB), .CFG_RD_STB(CFG_RD_STB), .RD_VALUE(RD_VALUE), .RD_VALID(RD_VALID),
	.OFFSET_VALID(OFFSET_VALID), .TIMER_ARMED(TIMER_ARMED), .IRQ(IRQ), .WAKE_REQ(WAKE_REQ)
);

`default_nettype wire
